// >>> design/ccm_top.sv
// cpu clock mode selection and oscillator watchdog
// assumes all inputs are synchronous to clk and the PLL levels arrive
// sampled; the cpu clock is produced as a registered level
`timescale 1ns/1ns
`include "ccm_cfg.svh"
module ccm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and oscillator levels
  input wire logic [2:0] clock_mode_strap_pins,
  input wire logic crystal_input_pin,
  input wire logic pll_free_clk,
  input wire logic pll_mult_clk,
  // system configuration bit and interrupt acknowledge
  input wire logic osc_watchdog_disable,
  input wire logic owd_irq_clear,
  // cpu clock and status
  output logic cpu_clk,
  output logic owd_irq,
  output logic clk_failed,
  // analog controls
  output ccm_pkg::ccm_ana_s ana
);
  // ========================================================
  // decode helpers
  function automatic logic [4:0] ccm_factor(input logic [2:0] c);
    logic [4:0] f;
    f = `CCM_FACTOR_RESET;
    case (c)
      `CCM_CODE_X4: f = 5'h04;
      `CCM_CODE_X3: f = 5'h03;
      `CCM_CODE_X8: f = 5'h08;
      `CCM_CODE_X5: f = 5'h05;
      `CCM_CODE_DIRECT: f = 5'h01;
      `CCM_CODE_X10: f = 5'h0A;
      `CCM_CODE_PRESCALE: f = 5'h01;
      default: f = 5'h10;
    endcase
    return f;
  endfunction : ccm_factor

  function automatic ccm_pkg::ccm_mode_e ccm_mode(input logic [2:0] c);
    ccm_pkg::ccm_mode_e m;
    m = ccm_pkg::CCM_PLL;
    if (c == `CCM_CODE_DIRECT) begin
      m = ccm_pkg::CCM_DIRECT;
    end else if (c == `CCM_CODE_PRESCALE) begin
      m = ccm_pkg::CCM_PRESCALE;
    end
    return m;
  endfunction : ccm_mode

  // ========================================================
  // reset release through two flip-flops
  // only the second flop feeds the state, so a late release cannot split it
  logic [1:0] rst_ff_r; // release shift chain
  logic rst_s_n;        // synchronised reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff_r <= 2'h0;
    end else begin
      rst_ff_r <= {rst_ff_r[0], 1'b1};
    end
  end
  assign rst_s_n = rst_ff_r[1];

  // ========================================================
  // next state
  ccm_pkg::ccm_state_s st_r;   // registered state
  ccm_pkg::ccm_state_s st_nxt; // next state
  logic xtal_tr;  // any input clock transition
  logic xtal_rise; // input clock rising edge
  logic pll_rise; // PLL free-running rising edge
  logic pll_tr;   // PLL free-running transition
  logic owd_en;   // watchdog active

  always_comb begin
    st_nxt = st_r;
    xtal_tr = crystal_input_pin != st_r.xtal_q;
    xtal_rise = crystal_input_pin && !st_r.xtal_q;
    pll_rise = pll_free_clk && !st_r.pll_q;
    pll_tr = pll_free_clk != st_r.pll_q;
    // watchdog only outside PLL modes and while not disabled
    owd_en = st_r.started && (st_r.mode != ccm_pkg::CCM_PLL)
             && !osc_watchdog_disable;
    st_nxt.xtal_q = crystal_input_pin;
    st_nxt.pll_q = pll_free_clk;
    st_nxt.ana.pll_resync = 1'b0;
    // first cycle after release captures the straps once
    if (!st_r.started) begin
      st_nxt.started = 1'b1;
      st_nxt.strap = clock_mode_strap_pins;
      st_nxt.mode = ccm_mode(clock_mode_strap_pins);
      st_nxt.ana.factor = ccm_factor(clock_mode_strap_pins);
    end
    // watchdog counter on PLL cycles, cleared by input transitions
    if (owd_en && !st_r.failed) begin
      if (xtal_tr) begin
        st_nxt.owd_cnt = `CCM_CNT_ZERO;
      end else if (pll_rise && st_r.owd_cnt == `CCM_OWD_LAST) begin
        st_nxt.failed = 1'b1;
        st_nxt.owd_cnt = `CCM_CNT_ZERO;
      end else if (pll_rise) begin
        st_nxt.owd_cnt = st_r.owd_cnt + `CCM_CNT_ONE;
      end
    end else if (!st_r.failed) begin
      st_nxt.owd_cnt = `CCM_CNT_ZERO;
    end
    // interrupt request: a new failure wins over the acknowledge
    if (owd_irq_clear) begin
      st_nxt.irq = 1'b0;
    end
    if (st_nxt.failed && !st_r.failed) begin
      st_nxt.irq = 1'b1;
    end
    // source switch waits for a PLL edge so no phase is cut short
    if (st_r.failed && !st_r.switched && pll_tr) begin
      st_nxt.switched = 1'b1;
    end
    // cpu clock per mechanism; both edges are exported as a level
    if (st_r.switched || st_nxt.switched) begin
      st_nxt.cpu_clk = pll_free_clk;
    end else if (st_r.failed) begin
      st_nxt.cpu_clk = st_r.cpu_clk; // hold until the PLL edge
    end else if (st_r.mode == ccm_pkg::CCM_DIRECT) begin
      st_nxt.cpu_clk = crystal_input_pin;
    end else if (st_r.mode == ccm_pkg::CCM_PRESCALE) begin
      if (xtal_rise) begin
        st_nxt.cpu_clk = !st_r.cpu_clk;
      end
    end else begin
      st_nxt.cpu_clk = pll_mult_clk;
      // resync once every factor input transitions
      if (xtal_tr) begin
        if (st_r.sync_cnt + `CCM_CNT_ONE >= st_r.ana.factor) begin
          st_nxt.sync_cnt = `CCM_CNT_ZERO;
          st_nxt.ana.pll_resync = st_r.started;
        end else begin
          st_nxt.sync_cnt = st_r.sync_cnt + `CCM_CNT_ONE;
        end
      end
    end
    // analog controls
    st_nxt.ana.osc_amp_bypass = st_nxt.mode == ccm_pkg::CCM_DIRECT;
    st_nxt.ana.pll_free_run = st_nxt.mode != ccm_pkg::CCM_PLL;
    st_nxt.ana.pll_power_on = (st_nxt.mode == ccm_pkg::CCM_PLL)
      || !osc_watchdog_disable || st_nxt.switched;
  end

  // ========================================================
  // state register
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_r <= '{started: 1'b0, strap: `CCM_STRAP_RESET, mode: ccm_pkg::CCM_PLL,
        xtal_q: 1'b0, pll_q: 1'b0, owd_cnt: `CCM_CNT_ZERO, failed: 1'b0,
        switched: 1'b0, cpu_clk: 1'b0, sync_cnt: `CCM_CNT_ZERO, irq: 1'b0,
        ana: '{pll_power_on: 1'b1, pll_free_run: 1'b0, osc_amp_bypass: 1'b0,
        factor: `CCM_FACTOR_RESET, pll_resync: 1'b0}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign cpu_clk = st_r.cpu_clk;
  assign owd_irq = st_r.irq;
  assign clk_failed = st_r.switched;
  assign ana = st_r.ana;

  // ========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  strap_hold_a: assert property ($past(st_r.started) |-> $stable(st_r.strap))
    else $error("strap changed after capture");
  factor_map_a: assert property (st_r.started |-> st_r.ana.factor == ccm_factor(st_r.strap))
    else $error("factor does not match strap");
  prescale_tog_a: assert property ((st_r.mode == ccm_pkg::CCM_PRESCALE && st_r.started
      && !st_r.failed && crystal_input_pin && !st_r.xtal_q) |=> cpu_clk != $past(cpu_clk))
    else $error("prescaler missed input edge");
  direct_follow_a: assert property ((st_r.mode == ccm_pkg::CCM_DIRECT && st_r.started
      && !st_r.failed) |=> cpu_clk == $past(crystal_input_pin))
    else $error("direct drive not following input");
  pll_off_a: assert property ((st_r.started && st_r.mode != ccm_pkg::CCM_PLL
      && osc_watchdog_disable && !st_r.failed) |=> !ana.pll_power_on)
    else $error("PLL on with watchdog disabled");
  pll_mode_owd_a: assert property (st_r.mode == ccm_pkg::CCM_PLL |-> !st_r.failed)
    else $error("watchdog acted in PLL mode");
  overflow_a: assert property ($rose(st_r.failed) |-> $past(st_r.owd_cnt) == `CCM_OWD_LAST
      && $past(pll_rise) && !$past(xtal_tr))
    else $error("failure without sixteen PLL cycles");
  fail_irq_a: assert property ($rose(st_r.failed) |-> owd_irq)
    else $error("failure without interrupt request");
  switch_hold_a: assert property (st_r.switched |=> st_r.switched && st_r.failed)
    else $error("switch-over released before reset");
  switch_glitch_a: assert property ($rose(st_r.switched) |-> $past(pll_tr))
    else $error("switch-over not on PLL edge");

  // watchdog counter rests at zero while the watchdog is off
  owd_rest_a: assert property ((!owd_en && !st_r.failed)
      |=> st_r.owd_cnt == `CCM_CNT_ZERO)
    else $error("watchdog counter at rest moved");
  // any input transition restarts the count
  cnt_clear_a: assert property ((owd_en && !st_r.failed && xtal_tr)
      |=> st_r.owd_cnt == `CCM_CNT_ZERO)
    else $error("input transition did not clear counter");
  // amplifier bypass only in direct drive
  bypass_map_a: assert property (st_r.started
      |-> ana.osc_amp_bypass == (st_r.mode == ccm_pkg::CCM_DIRECT))
    else $error("amplifier bypass does not match mode");
  // PLL modes pass the multiplied clock one cycle later
  pll_follow_a: assert property ((st_r.started && st_r.mode == ccm_pkg::CCM_PLL)
      |=> cpu_clk == $past(pll_mult_clk))
    else $error("PLL mode not following multiplied clock");
  // acknowledge clears a request once the failure is old
  irq_clear_a: assert property ((owd_irq_clear && st_r.failed) |=> !owd_irq)
    else $error("interrupt request not cleared");
  // resync pulses belong to the PLL modes only
  resync_pll_a: assert property (ana.pll_resync |-> st_r.mode == ccm_pkg::CCM_PLL)
    else $error("resync pulse outside PLL mode");
endmodule : ccm_top

// >>> design/ccm_cfg.svh
// constants of the cpu clock mode selector and oscillator watchdog
// assumes a single 100 MHz system clock samples every pin of the block
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH
// ==========================================================
// strap codes
`define CCM_STRAP_RESET 3'h7
`define CCM_CODE_X4 3'h7
`define CCM_CODE_X3 3'h6
`define CCM_CODE_X8 3'h5
`define CCM_CODE_X5 3'h4
`define CCM_CODE_DIRECT 3'h3
`define CCM_CODE_X10 3'h2
`define CCM_CODE_PRESCALE 3'h1
`define CCM_CODE_X16 3'h0
// ==========================================================
// factors and watchdog counts
`define CCM_FACTOR_RESET 5'h04
`define CCM_OWD_LAST 5'h0F
`define CCM_CNT_ZERO 5'h00
`define CCM_CNT_ONE 5'h01
`endif

// >>> design/ccm_pkg.sv
// types of the cpu clock mode selector and oscillator watchdog
// assumes ccm_cfg.svh holds the numeric constants
package ccm_pkg;
  // ========================================================
  // clock generation mechanism
  typedef enum logic [1:0] {CCM_PLL, CCM_DIRECT, CCM_PRESCALE} ccm_mode_e;
  // ========================================================
  // controls towards the analog PLL and oscillator
  typedef struct packed {
    logic pll_power_on;   // PLL powered
    logic pll_free_run;   // PLL at free-running frequency
    logic osc_amp_bypass; // oscillator amplifier bypassed
    logic [4:0] factor;   // multiply factor for PLL modes
    logic pll_resync;     // pulse: resync to input clock
  } ccm_ana_s;
  // ========================================================
  // whole block state
  typedef struct packed {
    logic started;        // straps captured
    logic [2:0] strap;    // captured clock mode strap bits
    ccm_mode_e mode;      // decoded mechanism
    logic xtal_q;         // previous crystal input level
    logic pll_q;          // previous PLL free-running level
    logic [4:0] owd_cnt;  // watchdog counter
    logic failed;         // input clock failure seen
    logic switched;       // cpu clock now from PLL free run
    logic cpu_clk;        // cpu clock output
    logic [4:0] sync_cnt; // input transitions since resync
    logic irq;            // watchdog interrupt request
    ccm_ana_s ana;        // analog controls
  } ccm_state_s;
endpackage : ccm_pkg

// >>> test/ccm_osc_model.sv
// oscillator side model: crystal level and PLL free and multiplied levels
// assumes the bench clock; every level changes 1 ns after a rising edge
`timescale 1ns/1ns
module ccm_osc_model (
  // clock
  input wire logic clk,
  // crystal running when high, frozen level when low
  input wire logic run,
  // sampled clock levels
  output logic xtal,
  output logic pll_free,
  output logic pll_mult
);
  // ========================================================
  // free-running cycle count
  int cnt_r = 0;
  logic go; // run level taken at the edge, before the bench moves it
  initial {xtal, pll_free, pll_mult} = 3'h0;
  // crystal half period 3 cycles, PLL free period 4, multiplied period 2
  always @(posedge clk) begin
    go = run;
    #1;
    cnt_r <= cnt_r + 1;
    pll_mult <= ~pll_mult;
    if (cnt_r % 2 == 1) pll_free <= ~pll_free;
    if (go && cnt_r % 3 == 2) xtal <= ~xtal;
  end
endmodule : ccm_osc_model

// >>> test/test_ccm_top.sv
// self-checking bench of the clock mode selector and oscillator watchdog
// assumes ccm_osc_model plays the oscillator; inputs change 1 ns after edges
`timescale 1ns/1ns
module test_ccm_top;
  // ========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h7;
  logic run = 1'b1;
  logic dis = 1'b0;
  logic clr = 1'b0;
  logic xtal, pfree, pmult, cpu_clk, owd_irq, clk_failed;
  logic x_q, p_q, m_q; // source levels seen at the last edge
  ccm_pkg::ccm_ana_s ana;
  int fail_count = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) {x_q, p_q, m_q} <= {xtal, pfree, pmult};
  ccm_osc_model u_ccm_osc_model (.clk(clk), .run(run), .xtal(xtal), .pll_free(pfree),
    .pll_mult(pmult));
  ccm_top u_ccm_top (.clk(clk), .rst_n(rst_n), .clock_mode_strap_pins(strap),
    .crystal_input_pin(xtal), .pll_free_clk(pfree), .pll_mult_clk(pmult),
    .osc_watchdog_disable(dis), .owd_irq_clear(clr), .cpu_clk(cpu_clk), .owd_irq(owd_irq),
    .clk_failed(clk_failed), .ana(ana));
  // ========================================================
  // shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // watched levels by number: irq, failed, crystal, PLL free, PLL multiplied
  localparam int sel_irq = 0;
  localparam int sel_fail = 1;
  localparam int sel_xtal = 2;
  localparam int sel_pfree = 3;
  localparam int sel_pmult = 4;
  function automatic logic pick(input int sel);
    logic [4:0] v;
    v = {m_q, p_q, x_q, clk_failed, owd_irq};
    return v[sel];
  endfunction : pick
  // bounded wait for a design flag
  task automatic wait_hi(input int sel, input int lim);
    for (int i = 0; i < lim && pick(sel) !== 1'b1; i++) tick();
    check("wait", pick(sel), 1'b1);
    if (pick(sel) !== 1'b1) final_report();
  endtask : wait_hi
  // cpu clock must equal the given source one cycle later
  task automatic follow(input int sel, input int n);
    repeat (n) begin
      tick();
      check("cpu_clk", cpu_clk, pick(sel));
    end
  endtask : follow
  task automatic do_reset(input logic [2:0] code, input logic d);
    rst_n = 1'b0;
    strap = code;
    dis = d;
    run = 1'b1;
    repeat (2) tick();
    rst_n = 1'b1;
    repeat (5) tick();
  endtask : do_reset
  // ========================================================
  // scenarios
  task automatic t_direct();
    do_reset(3'h3, 1'b0);
    strap = 3'h7; // later strap change must be ignored
    check("bypass", ana.osc_amp_bypass, 1'b1);
    check("pll_on", {ana.pll_power_on, ana.pll_free_run}, 2'h3);
    follow(sel_xtal, 30);
    check("irq_idle", owd_irq, 1'b0);
    run = 1'b0;
    repeat (56) tick();
    check("irq_early", owd_irq, 1'b0);
    wait_hi(sel_irq, 20);
    wait_hi(sel_fail, 8);
    follow(sel_pfree, 12);
    run = 1'b1;
    follow(sel_pfree, 30);
    check("stay", clk_failed, 1'b1);
    clr = 1'b1;
    tick();
    clr = 1'b0;
    tick();
    check("irq_clr", owd_irq, 1'b0);
  endtask : t_direct
  task automatic t_prescale();
    int tg;
    int rs;
    tg = 0;
    rs = 0;
    do_reset(3'h1, 1'b1);
    check("restored", clk_failed, 1'b0);
    check("pll_off", ana.pll_power_on, 1'b0);
    repeat (60) begin
      logic c0;
      logic x0;
      c0 = cpu_clk;
      x0 = x_q;
      tick();
      tg += (cpu_clk !== c0);
      rs += (x_q && !x0);
    end
    check("halves", (tg >= rs - 1 && tg <= rs + 1 && rs > 8), 1'b1);
    run = 1'b0;
    repeat (100) tick();
    check("no_owd", {owd_irq, clk_failed}, 2'h0);
  endtask : t_prescale
  task automatic t_pll();
    logic [2:0] codes [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h0};
    logic [4:0] facs [6] = '{5'h04, 5'h03, 5'h08, 5'h05, 5'h0A, 5'h10};
    int pulses;
    for (int k = 0; k < 6; k++) begin
      do_reset(codes[k], 1'b0);
      check("factor", ana.factor, facs[k]);
      check("pll_run", {ana.pll_free_run, ana.osc_amp_bypass}, 2'h0);
      follow(sel_pmult, 8);
      pulses = 0;
      repeat (18 * facs[k]) begin
        tick();
        pulses += ana.pll_resync;
      end
      check("resync", (pulses >= 5 && pulses <= 7), 1'b1);
    end
    run = 1'b0;
    repeat (100) tick();
    check("owd_off", {owd_irq, clk_failed}, 2'h0);
  endtask : t_pll
  // ========================================================
  // main sequence
  initial begin
    t_direct();
    t_prescale();
    t_pll();
    final_report();
  end
endmodule : test_ccm_top
